/* File: src/pmic_pkg.sv */
`default_nettype none
package pmic_pkg;
  // register bus widths and event count
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int NUM_EV = 16;

  // register offsets
  localparam logic [7:0] OFS_SUPPLY_GOOD = 8'h02;
  localparam logic [7:0] OFS_IRQ_MASK_LO = 8'h03;
  localparam logic [7:0] OFS_IRQ_MASK_HI = 8'h04;
  localparam logic [7:0] OFS_IRQ_ACK_LO  = 8'h05;
  localparam logic [7:0] OFS_IRQ_ACK_HI  = 8'h06;
  localparam logic [7:0] OFS_PG_MASK     = 8'h07;
  localparam logic [7:0] OFS_SOFT_RESET  = 8'h08;

  // power-up defaults: nothing masked for irq, all masked for faults
  localparam logic [7:0] IRQ_MASK_RST = 8'h00;
  localparam logic [7:0] PG_MASK_RST  = 8'hFF;

  // soft reset register fields
  localparam int SRST_REQ_BIT  = 0;
  localparam int RAMLOAD_N_BIT = 1;

  // supply bits of the event vector
  localparam logic [15:0] SUPPLY_EV_MASK = 16'h00FF;
  localparam logic [15:0] ALL_EV_MASK    = 16'hFFFF;

  // timing
  localparam int CLK_HZ          = 100_000_000;
  localparam int HOTPLUG_TIME_US = 1000;
  localparam int HOTPLUG_CYCLES  = HOTPLUG_TIME_US * (CLK_HZ / 1_000_000);
  localparam int HP_CNT_W        = 20;

  // monitored inputs, supply faults in the low byte
  typedef struct packed {
    logic       thermal_fault;
    logic       adc_stat;
    logic       battery_stat;
    logic       charger_stat;
    logic       sys_on_usb;
    logic       input_overvoltage_protect;
    logic       usb_present;
    logic       ac_present;
    logic [7:0] supply_fault;
  } monitor_s;

  // register bus request
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_s;

  // operating modes
  typedef enum logic [3:0] {
    ST_OFF,
    ST_LOAD,
    ST_HOTPLUG,
    ST_ENABLE,
    ST_SEQUENCE,
    ST_RESET,
    ST_ACTIVE,
    ST_SLEEP
  } mode_e;
endpackage
`default_nettype wire

/* File: src/change_detect.sv */
`default_nettype none
module change_detect #(
  parameter int W = 16
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] level,
  input  wire logic [W-1:0] blank,
  output logic      [W-1:0] toggled
);
  logic [W-1:0] prev_ff;

  // previous level always tracks, so blanked bits never fire late
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_ff <= '0;
    end else begin
      prev_ff <= level;
    end
  end

  // change in either direction
  assign toggled = (level ^ prev_ff) & ~blank;
endmodule
`default_nettype wire

/* File: src/irq_sticky.sv */
`default_nettype none
module irq_sticky #(
  parameter int W = 16
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         init,
  input  wire logic [W-1:0] set,
  input  wire logic [W-1:0] clr,
  output logic      [W-1:0] stat
);
  // sticky bits, a set in the clearing cycle wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stat <= '0;
    end else if (init) begin
      stat <= '0;
    end else begin
      stat <= (stat & ~clr) | set;
    end
  end
endmodule
`default_nettype wire

/* File: src/pmic_irq_seq.sv */
`default_nettype none
module pmic_irq_seq #(
  parameter int HOTPLUG_CYCLES = pmic_pkg::HOTPLUG_CYCLES
) (
  input  wire logic                           clk,
  input  wire logic                           rstn,
  input  wire pmic_pkg::reg_req_s             reg_req,
  output logic     [pmic_pkg::DATA_W-1:0]     rdata,
  input  wire pmic_pkg::monitor_s             mon,
  input  wire logic                           undervoltage_lockout,
  input  wire logic                           system_voltage_sense,
  input  wire logic                           hardware_reset_in_n,
  input  wire logic                           reset_timer_expired,
  output logic                                reset_timer_start,
  output logic                                host_reset_out_n,
  output logic                                serial_reset,
  output logic                                irq,
  output logic                                int_od_out,
  output logic                                int_od_oe,
  output logic                                sleep_mode
);
  localparam int NE = pmic_pkg::NUM_EV;

  logic [1:0]              rst_sync_ff;
  logic                    rst_n;
  pmic_pkg::mode_e         mode_ff;
  pmic_pkg::mode_e         nxt_mode;
  logic [NE-1:0]           irq_mask_ff;
  logic [7:0]              pg_mask_ff;
  logic                    soft_req_ff;
  logic                    ramload_n_ff;
  logic                    thermal_lock_ff;
  logic [pmic_pkg::HP_CNT_W-1:0] hp_cnt_ff;
  logic [7:0]              rdata_ff;
  logic [7:0]              nxt_rdata;
  logic [NE-1:0]           ev_level;
  logic [NE-1:0]           blank;
  logic [NE-1:0]           toggled;
  logic [NE-1:0]           ev_set;
  logic [NE-1:0]           ack_clr;
  logic [NE-1:0]           ack;
  logic                    load_defaults;
  logic                    pg_check;
  logic                    pg_fault;
  logic                    hp_active;
  logic                    host_rst_req;
  logic                    wr_soft;

  // reset release through two flops
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync_ff <= 2'b00;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  // mode decode
  assign load_defaults = (mode_ff == pmic_pkg::ST_OFF) || (mode_ff == pmic_pkg::ST_LOAD);
  assign pg_check      = (mode_ff == pmic_pkg::ST_ACTIVE);
  assign hp_active     = (hp_cnt_ff != '0);
  assign wr_soft       = reg_req.wr && (reg_req.addr == pmic_pkg::OFS_SOFT_RESET);

  // monitored parameters form the event vector
  assign ev_level = mon;

  // supply comparators blanked outside the check mode
  always_comb begin
    if (load_defaults) begin
      blank = pmic_pkg::ALL_EV_MASK;
    end else if (!pg_check) begin
      blank = pmic_pkg::SUPPLY_EV_MASK;
    end else begin
      blank = '0;
    end
  end

  change_detect #(.W(NE)) u_change (
    .clk     (clk),
    .rst_n   (rst_n),
    .level   (ev_level),
    .blank   (blank),
    .toggled (toggled)
  );

  // only unmasked toggles are latched
  assign ev_set = toggled & ~irq_mask_ff;

  // read of an acknowledge register clears it
  always_comb begin
    ack_clr = '0;
    if (reg_req.rd && reg_req.addr == pmic_pkg::OFS_IRQ_ACK_LO) begin
      ack_clr[7:0] = 8'hFF;
    end
    if (reg_req.rd && reg_req.addr == pmic_pkg::OFS_IRQ_ACK_HI) begin
      ack_clr[15:8] = 8'hFF;
    end
  end

  irq_sticky #(.W(NE)) u_ack (
    .clk   (clk),
    .rst_n (rst_n),
    .init  (load_defaults),
    .set   (ev_set),
    .clr   (ack_clr),
    .stat  (ack)
  );

  // interrupt level and open-drain pin
  assign irq        = |(ack & ~irq_mask_ff);
  assign int_od_out = 1'b0;
  assign int_od_oe  = irq && !load_defaults && (mode_ff != pmic_pkg::ST_ENABLE);

  // supply fault inputs: under 90% of target, boost: overvoltage reached
  assign pg_fault = pg_check && |(mon.supply_fault & ~pg_mask_ff);

  // host reset requests seen in the check mode
  assign host_rst_req = !hardware_reset_in_n || soft_req_ff;

  // mode sequencing
  always_comb begin
    nxt_mode = mode_ff;
    case (mode_ff)
      pmic_pkg::ST_OFF: begin
        nxt_mode = pmic_pkg::ST_LOAD;
      end
      pmic_pkg::ST_LOAD: begin
        nxt_mode = pmic_pkg::ST_HOTPLUG;
      end
      pmic_pkg::ST_HOTPLUG: begin
        nxt_mode = pmic_pkg::ST_ENABLE;
      end
      pmic_pkg::ST_ENABLE: begin
        if (system_voltage_sense) begin
          nxt_mode = pmic_pkg::ST_SEQUENCE;
        end
      end
      pmic_pkg::ST_SEQUENCE: begin
        nxt_mode = pmic_pkg::ST_RESET;
      end
      pmic_pkg::ST_RESET: begin
        if (reset_timer_expired) begin
          nxt_mode = pmic_pkg::ST_ACTIVE;
        end
      end
      pmic_pkg::ST_ACTIVE: begin
        if (mon.thermal_fault) begin
          nxt_mode = pmic_pkg::ST_SLEEP;
        end else if (pg_fault) begin
          nxt_mode = hp_active ? pmic_pkg::ST_ENABLE : pmic_pkg::ST_SLEEP;
        end else if (host_rst_req) begin
          nxt_mode = pmic_pkg::ST_RESET;
        end
      end
      pmic_pkg::ST_SLEEP: begin
        if (!thermal_lock_ff && !hardware_reset_in_n) begin
          nxt_mode = pmic_pkg::ST_ENABLE;
        end
      end
      default: begin
        nxt_mode = pmic_pkg::ST_OFF;
      end
    endcase
    if (undervoltage_lockout) begin
      nxt_mode = pmic_pkg::ST_OFF;
    end
  end

  // mode register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_ff <= pmic_pkg::ST_OFF;
    end else begin
      mode_ff <= nxt_mode;
    end
  end

  // mode outputs
  assign host_reset_out_n  = pg_check || (mode_ff == pmic_pkg::ST_SLEEP);
  assign reset_timer_start = (mode_ff == pmic_pkg::ST_RESET);
  assign serial_reset      = !host_reset_out_n;
  assign sleep_mode        = (mode_ff == pmic_pkg::ST_SLEEP);

  // thermal sleep lock, released only by power removal
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      thermal_lock_ff <= 1'b0;
    end else if (load_defaults) begin
      thermal_lock_ff <= 1'b0;
    end else if (pg_check && mon.thermal_fault) begin
      thermal_lock_ff <= 1'b1;
    end
  end

  // hotplug deglitch counter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hp_cnt_ff <= '0;
    end else if (load_defaults) begin
      hp_cnt_ff <= '0;
    end else if (mode_ff == pmic_pkg::ST_HOTPLUG) begin
      hp_cnt_ff <= pmic_pkg::HP_CNT_W'(HOTPLUG_CYCLES);
    end else if (hp_active) begin
      hp_cnt_ff <= hp_cnt_ff - 1'b1;
    end
  end

  // mask registers, defaults on power-up load
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask_ff <= {pmic_pkg::IRQ_MASK_RST, pmic_pkg::IRQ_MASK_RST};
      pg_mask_ff  <= pmic_pkg::PG_MASK_RST;
    end else if (load_defaults) begin
      irq_mask_ff <= {pmic_pkg::IRQ_MASK_RST, pmic_pkg::IRQ_MASK_RST};
      pg_mask_ff  <= pmic_pkg::PG_MASK_RST;
    end else if (reg_req.wr) begin
      case (reg_req.addr)
        pmic_pkg::OFS_IRQ_MASK_LO: irq_mask_ff[7:0]  <= reg_req.wdata;
        pmic_pkg::OFS_IRQ_MASK_HI: irq_mask_ff[15:8] <= reg_req.wdata;
        pmic_pkg::OFS_PG_MASK:     pg_mask_ff        <= reg_req.wdata;
        default:                   pg_mask_ff        <= pg_mask_ff;
      endcase
    end
  end

  // software reset request, consumed on entry to reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      soft_req_ff <= 1'b0;
    end else if (load_defaults) begin
      soft_req_ff <= 1'b0;
    end else if (wr_soft && reg_req.wdata[pmic_pkg::SRST_REQ_BIT]) begin
      soft_req_ff <= 1'b1;
    end else if (mode_ff == pmic_pkg::ST_RESET) begin
      soft_req_ff <= 1'b0;
    end
  end

  // defaults-loaded flag, low once registers hold defaults
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ramload_n_ff <= 1'b1;
    end else if (mode_ff == pmic_pkg::ST_OFF) begin
      ramload_n_ff <= 1'b1;
    end else if (mode_ff == pmic_pkg::ST_LOAD) begin
      ramload_n_ff <= 1'b0;
    end
  end

  // read mux
  always_comb begin
    nxt_rdata = 8'h00;
    if (reg_req.rd) begin
      case (reg_req.addr)
        pmic_pkg::OFS_SUPPLY_GOOD: nxt_rdata = ~mon.supply_fault;
        pmic_pkg::OFS_IRQ_MASK_LO: nxt_rdata = irq_mask_ff[7:0];
        pmic_pkg::OFS_IRQ_MASK_HI: nxt_rdata = irq_mask_ff[15:8];
        pmic_pkg::OFS_IRQ_ACK_LO:  nxt_rdata = ack[7:0];
        pmic_pkg::OFS_IRQ_ACK_HI:  nxt_rdata = ack[15:8];
        pmic_pkg::OFS_PG_MASK:     nxt_rdata = pg_mask_ff;
        pmic_pkg::OFS_SOFT_RESET: begin
          nxt_rdata[pmic_pkg::SRST_REQ_BIT]  = soft_req_ff;
          nxt_rdata[pmic_pkg::RAMLOAD_N_BIT] = ramload_n_ff;
        end
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  // read data one cycle after the strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end
  assign rdata = rdata_ff;

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  property p_toggle;
    pg_check && $changed(mon.ac_present) && !irq_mask_ff[8] |=> ack[8] ##0 irq;
  endproperty
  a_toggle: assert property (p_toggle) else $error("unmasked toggle not latched");

  // bit 0 or bit 9 masked in the latching cycle never rises
  property p_mask;
    ($past(irq_mask_ff[0]) |-> !$rose(ack[0])) and ($past(irq_mask_ff[9]) |-> !$rose(ack[9]));
  endproperty
  a_mask: assert property (p_mask) else $error("masked event latched");

  property p_blank;
    !pg_check |=> (ack[7:0] & ~$past(ack[7:0])) == 8'h00;
  endproperty
  a_blank: assert property (p_blank) else $error("supply fault latched while blanked");

  property p_pgfault;
    pg_fault && !mon.thermal_fault && !undervoltage_lockout |=>
      mode_ff == pmic_pkg::ST_SLEEP || mode_ff == pmic_pkg::ST_ENABLE;
  endproperty
  a_pgfault: assert property (p_pgfault) else $error("supply fault ignored");

  property p_thermal;
    pg_check && mon.thermal_fault && !undervoltage_lockout |=>
      sleep_mode ##1 (sleep_mode || undervoltage_lockout || $past(undervoltage_lockout));
  endproperty
  a_thermal: assert property (p_thermal) else $error("thermal sleep not held");

  property p_hwrst;
    pg_check && !hardware_reset_in_n && !mon.thermal_fault && !pg_fault && !undervoltage_lockout |=>
      !host_reset_out_n && reset_timer_start && serial_reset;
  endproperty
  a_hwrst: assert property (p_hwrst) else $error("hardware reset gave no pulse");

  property p_swrst;
    pg_check && wr_soft && reg_req.wdata[pmic_pkg::SRST_REQ_BIT] && !host_rst_req && !pg_fault
      && !mon.thermal_fault && !undervoltage_lockout
      ##1 !pg_fault && !mon.thermal_fault && !undervoltage_lockout |=> !host_reset_out_n;
  endproperty
  a_swrst: assert property (p_swrst) else $error("software reset gave no pulse");

  property p_timer;
    mode_ff == pmic_pkg::ST_RESET && !reset_timer_expired && !undervoltage_lockout |=> !host_reset_out_n;
  endproperty
  a_timer: assert property (p_timer) else $error("host reset ended before timer");

  property p_undervoltage_lockout;
    undervoltage_lockout |=> mode_ff == pmic_pkg::ST_OFF && !int_od_oe && !host_reset_out_n ##1 ack == '0;
  endproperty
  a_undervoltage_lockout: assert property (p_undervoltage_lockout) else $error("active under lockout");

  property p_load;
    mode_ff == pmic_pkg::ST_LOAD |=> irq_mask_ff == 16'h0000 && pg_mask_ff == 8'hFF && !ramload_n_ff;
  endproperty
  a_load: assert property (p_load) else $error("defaults not loaded");

  property p_enable;
    mode_ff == pmic_pkg::ST_ENABLE |-> !host_reset_out_n && !int_od_oe && serial_reset;
  endproperty
  a_enable: assert property (p_enable) else $error("enable mode outputs wrong");

  property p_pin;
    !load_defaults && mode_ff != pmic_pkg::ST_ENABLE |-> int_od_oe == (|(ack & ~irq_mask_ff));
  endproperty
  a_pin: assert property (p_pin) else $error("irq pin disagrees with pending");

  c_toggle: cover property (pg_check && $rose(irq));
  c_sleep: cover property (pg_check ##1 sleep_mode);
  c_hwrst: cover property (pg_check && !hardware_reset_in_n ##1 !host_reset_out_n);
  c_ackrd: cover property (irq && reg_req.rd && reg_req.addr == pmic_pkg::OFS_IRQ_ACK_HI);
endmodule
`default_nettype wire

/* File: tb/host_side_model.sv */
`default_nettype none
module host_side_model (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic [7:0] delay,
  input  wire logic       reset_timer_start,
  input  wire logic       int_od_out,
  input  wire logic       int_od_oe,
  output logic            reset_timer_expired,
  output logic            int_line
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cnt_ff;

  // capacitor timer: runs while started, discharges when stopped
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_ff <= 8'h00;
    end else if (!reset_timer_start) begin
      cnt_ff <= 8'h00;
    end else if (cnt_ff != 8'hff) begin
      cnt_ff <= cnt_ff + 8'h01;
    end
  end

  // expired only while started, so a stale level never leaks out
  assign reset_timer_expired = reset_timer_start && (cnt_ff >= delay);

  // board pull-up on the open-drain line
  assign int_line = int_od_oe ? int_od_out : 1'b1;
endmodule
`default_nettype wire

/* File: tb/pmic_interrupt_and_fault_sequencing_bench.sv */
`default_nettype none
module pmic_interrupt_and_fault_sequencing_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic               clk;
  logic               rstn;
  pmic_pkg::reg_req_s req;
  logic [7:0]         rdata;
  pmic_pkg::monitor_s mon;
  logic               lockout;
  logic               sys_sense;
  logic               hw_rst_n;
  logic               tmr_exp;
  logic               tmr_start;
  logic               host_rst_n;
  logic               ser_rst;
  logic               irq;
  logic               od_out;
  logic               od_oe;
  logic               sleep;
  logic               int_line;
  logic [7:0]         tmr_delay;
  logic [7:0]         exp_q[$];
  logic               rd_pend;
  logic [7:0]         r;
  int                 n_errors;
  int                 checked;
  int                 seed;
  int                 k;

  pmic_irq_seq #(.HOTPLUG_CYCLES(20)) u_dut (
    .clk(clk), .rstn(rstn), .reg_req(req), .rdata(rdata), .mon(mon),
    .undervoltage_lockout(lockout), .system_voltage_sense(sys_sense),
    .hardware_reset_in_n(hw_rst_n), .reset_timer_expired(tmr_exp), .reset_timer_start(tmr_start),
    .host_reset_out_n(host_rst_n), .serial_reset(ser_rst), .irq(irq), .int_od_out(od_out),
    .int_od_oe(od_oe), .sleep_mode(sleep)
  );

  host_side_model u_host (
    .clk(clk), .rstn(rstn), .delay(tmr_delay), .reset_timer_start(tmr_start),
    .int_od_out(od_out), .int_od_oe(od_oe), .reset_timer_expired(tmr_exp), .int_line(int_line)
  );

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic final_report;
    if (n_errors == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req.wr <= 1'b1;
    req.addr <= a;
    req.wdata <= d;
    @(posedge clk);
    req.wr <= 1'b0;
  endtask

  // note the expected data, then issue a one-cycle read
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge clk);
    req.rd <= 1'b1;
    req.addr <= a;
    @(posedge clk);
    req.rd <= 1'b0;
    @(negedge clk);
  endtask

  // drive one monitored bit, give the latch time, settle
  task automatic setmon(input int b, input logic v);
    @(posedge clk);
    mon[b] <= v;
    tick(3);
    @(negedge clk);
  endtask

  task automatic ev(input int b, input logic [7:0] a, input logic [7:0] e);
    setmon(b, ~mon[b]);
    rd(a, e);
  endtask

  task automatic pulse_hw;
    @(posedge clk);
    hw_rst_n <= 1'b0;
    @(posedge clk);
    hw_rst_n <= 1'b1;
  endtask

  // bounded wait for a host reset level
  task automatic wait_hr(input logic v);
    int i;
    for (i = 0; i < 300; i++) begin
      @(negedge clk);
      if (host_rst_n === v) return;
    end
    n_errors++;
    $display("CHECK FAILED host reset expected %b seen %b", v, host_rst_n);
    final_report();
  endtask

  // count low cycles of the host reset pulse
  task automatic measure(input logic [7:0] d);
    int n;
    wait_hr(1'b0);
    chk("serial reset", 8'h01, ser_rst);
    n = 1;
    while (host_rst_n === 1'b0 && n < 300) begin
      @(negedge clk);
      if (host_rst_n === 1'b0) n++;
    end
    chk("reset pulse length", d + 8'h01, n[7:0]);
  endtask

  // read data watcher: oldest note against the answer cycle
  always @(posedge clk) begin
    rd_pend <= req.rd;
  end
  always @(negedge clk) begin
    if (rd_pend) begin
      if (exp_q.size() == 0) begin
        n_errors++;
        $display("CHECK FAILED read data expected none seen %h", rdata);
      end else begin
        chk("read data", exp_q.pop_front(), rdata);
      end
    end
  end

  // hang guard
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    $display("CHECK FAILED run length expected end seen timeout");
    final_report();
  end

  initial begin
    seed = 27165;
    n_errors = 0;
    checked = 0;
    rstn = 1'b0;
    req = '0;
    mon = '0;
    lockout = 1'b0;
    sys_sense = 1'b0;
    hw_rst_n = 1'b1;
    tmr_delay = 8'h05;
    tick(8);
    rstn <= 1'b1;
    tick(6);
    @(negedge clk);
    chk("host reset", 8'h00, host_rst_n);
    chk("int enable", 8'h00, od_oe);
    // supply comparators ignored before the rail is up
    setmon(3, 1'b1);
    setmon(3, 1'b0);
    rd(pmic_pkg::OFS_IRQ_ACK_LO, 8'h00);
    rd(pmic_pkg::OFS_IRQ_MASK_LO, 8'h00);
    rd(pmic_pkg::OFS_IRQ_MASK_HI, 8'h00);
    rd(pmic_pkg::OFS_PG_MASK, 8'hff);
    rd(pmic_pkg::OFS_SOFT_RESET, 8'h00);
    rd(8'h01, 8'h00);
    // rail up: sequence, reset pulse, active
    @(posedge clk);
    sys_sense <= 1'b1;
    // skip the sequence cycles, the reset mode starts two edges later
    tick(2);
    measure(8'h05);
    chk("serial reset", 8'h00, ser_rst);
    // random irq mask against a random supply event
    r = 8'($random(seed));
    k = $random(seed) & 7;
    wr(pmic_pkg::OFS_IRQ_MASK_LO, r);
    rd(pmic_pkg::OFS_IRQ_MASK_LO, r);
    setmon(k, 1'b1);
    chk("irq", {7'h00, !r[k]}, irq);
    rd(pmic_pkg::OFS_SUPPLY_GOOD, ~(8'h01 << k));
    rd(pmic_pkg::OFS_IRQ_ACK_LO, r[k] ? 8'h00 : 8'h01 << k);
    ev(k, pmic_pkg::OFS_IRQ_ACK_LO, r[k] ? 8'h00 : 8'h01 << k);
    wr(pmic_pkg::OFS_IRQ_MASK_LO, 8'h00);
    // status sources 8 to 14, both directions
    for (int b = 8; b < 15; b++) begin
      setmon(b, 1'b1);
      chk("irq", 8'h01, irq);
      chk("int pin", 8'h00, int_line);
      rd(pmic_pkg::OFS_IRQ_ACK_HI, 8'h01 << (b - 8));
      chk("int pin", 8'h01, int_line);
      ev(b, pmic_pkg::OFS_IRQ_ACK_HI, 8'h01 << (b - 8));
    end
    // masked source leaves no request
    wr(pmic_pkg::OFS_IRQ_MASK_HI, 8'h02);
    ev(9, pmic_pkg::OFS_IRQ_ACK_HI, 8'h00);
    wr(pmic_pkg::OFS_IRQ_MASK_HI, 8'h00);
    // software reset with a short timer
    tmr_delay <= 8'h04;
    wr(pmic_pkg::OFS_SOFT_RESET, 8'h01);
    measure(8'h04);
    rd(pmic_pkg::OFS_SOFT_RESET, 8'h00);
    // hardware reset with a long timer
    tmr_delay <= 8'h0c;
    pulse_hw();
    measure(8'h0c);
    // unmasked supply fault puts the part to sleep
    wr(pmic_pkg::OFS_PG_MASK, 8'hfe);
    setmon(0, 1'b1);
    chk("sleep", 8'h01, sleep);
    setmon(0, 1'b0);
    pulse_hw();
    wait_hr(1'b0);
    wait_hr(1'b1);
    // thermal sleep survives the reset pin
    setmon(15, 1'b1);
    chk("sleep", 8'h01, sleep);
    pulse_hw();
    tick(4);
    @(negedge clk);
    chk("sleep", 8'h01, sleep);
    // lockout holds everything off, then a clean power-up
    @(posedge clk);
    lockout <= 1'b1;
    mon <= '0;
    tick(10);
    @(negedge clk);
    chk("sleep", 8'h00, sleep);
    chk("host reset", 8'h00, host_rst_n);
    chk("int enable", 8'h00, od_oe);
    @(posedge clk);
    lockout <= 1'b0;
    tick(6);
    rd(pmic_pkg::OFS_PG_MASK, 8'hff);
    final_report();
  end
endmodule
`default_nettype wire
